// ### rtl/hsf_pkg.sv
// Shared types and constants of the hot swap friendly control block
package hsf_pkg;

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  localparam int unsigned HSF_NPINS     = 4;
  localparam int unsigned HSF_PIN_RST   = 0;
  localparam int unsigned HSF_PIN_HLTHY = 1;
  localparam int unsigned HSF_PIN_LRST  = 2;
  localparam int unsigned HSF_PIN_LATCH = 3;
  // Synchroniser reset values: resets asserted, unhealthy, latch open
  localparam logic [HSF_NPINS-1:0] HSF_PIN_RST_VAL = 4'h2;

  // ----------------------------------------------------------------
  // Levels
  // ----------------------------------------------------------------
  localparam logic HSF_LATCH_CLOSED = 1'b1;
  localparam logic HSF_LED_LIT      = 1'b0;
  localparam logic HSF_ENUM_ACT     = 1'b0;
  localparam logic HSF_LRST_ACT     = 1'b0;
  localparam logic HSF_HEALTHY_BAD  = 1'b1;

  // ----------------------------------------------------------------
  // Reset values of control and status bits
  // ----------------------------------------------------------------
  localparam logic HSF_FLAG_RST     = 1'b0;
  localparam logic HSF_MASK_RST     = 1'b0;
  localparam logic HSF_HOLD_RST     = 1'b0;
  localparam logic HSF_BURST_RST    = 1'b1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    HSF_S_RESET,
    HSF_S_LOAD,
    HSF_S_HOLD,
    HSF_S_LATCH,
    HSF_S_RUN,
    HSF_S_EJECT
  } hsf_state_t;

  // Host software writes, one-cycle strobes with data
  typedef struct packed {
    logic ins_wr;
    logic ext_wr;
    logic mask_wr;
    logic mask_val;
    logic led_wr;
    logic led_val;
  } hsf_host_wr_t;

  // Local processor-bus host writes
  typedef struct packed {
    logic hold_off_clr;
    logic soft_rst_wr;
    logic soft_rst_val;
  } hsf_local_wr_t;

  // Status seen by both hosts
  typedef struct packed {
    logic insertion_flag;
    logic extraction_flag;
    logic led_on_bit;
    logic enum_mask_bit;
    logic pci_hold_off;
    logic soft_local_reset_bit;
    logic burst_option;
  } hsf_status_t;

endpackage

// ### rtl/hsf_ctrl.sv
// Hot swap friendly control: LED, latch, resets, insertion/extraction
`timescale 1ns/100ps
`default_nettype none

// Function
// R01 - LED pin driven low while unhealthy or while software LED bit set
// R02 - LED dark means pin released, never driven high
// R03 - Latch input low means open, high means closed
// R04 - Internal reset while PCI reset asserted or healthy input high
// R05 - While unhealthy stay in reset, release all outputs except LED
// R06 - Healthy and PCI reset low drive local reset out; unhealthy releases it
// R07 - Sample option pins on healthy fall, PCI reset rise, local reset rise
// R08 - On leaving reset load from EEPROM when loading is enabled
// R09 - After load set insertion flag, assert ENUM#, accept config cycles
// R10 - Hold-off option withholds ENUM# and retries config cycles
// R11 - Local host clears hold-off; then insertion, ENUM#, accept config
// R12 - Host write to insertion or mask bit releases ENUM#; clears insertion
// R13 - Latch falling edge sets extraction flag and asserts ENUM#
// R14 - Host writes extraction bit; device clears it and releases ENUM#
// R15 - Host quiesces card before setting LED bit to allow removal
// R16 - Latch reclosed without reset resumes insertion, no EEPROM reload
// R17 - Mask bit set suppresses ENUM# but status flags still set
// R18 - Soft reset bit asserts local reset out until cleared or reset
module hsf_ctrl
  import hsf_pkg::*;
(
  // Clock and power-on reset
  input  wire logic          clk,
  input  wire logic          reset_n,
  // Backplane and local pins
  input  wire logic          pci_rst_n,
  input  wire logic          board_healthy_n,
  input  wire logic          local_reset_in_n,
  input  wire logic          latch_switch_in,
  input  wire logic          pci_hold_off_pin,
  input  wire logic          burst_option_pin,
  // Open-drain LED
  output logic               eject_led_out,
  output logic               eject_led_oe,
  // Open-drain ENUM#
  output logic               enum_out_n,
  output logic               enum_oe,
  // Local-bus reset output
  output logic               local_reset_out_n,
  output logic               local_reset_oe,
  // EEPROM loader
  input  wire logic          eeprom_load_en,
  output logic               eeprom_start,
  input  wire logic          eeprom_done,
  // Register writes from both hosts
  input  wire hsf_pkg::hsf_host_wr_t  host_wr,
  input  wire hsf_pkg::hsf_local_wr_t local_wr,
  // Status and configuration cycle control
  output hsf_pkg::hsf_status_t status,
  output logic               cfg_accept,
  output logic               cfg_retry,
  output logic               outputs_hiz
);
  import hsf_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [HSF_NPINS-1:0] meta_q;
  logic [HSF_NPINS-1:0] sync_q;
  logic [HSF_NPINS-1:0] last_q;
  logic [HSF_NPINS-1:0] pins;
  assign pins = {latch_switch_in, local_reset_in_n,
                 board_healthy_n, pci_rst_n};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= HSF_PIN_RST_VAL;
      sync_q <= HSF_PIN_RST_VAL;
      last_q <= HSF_PIN_RST_VAL;
    end else begin
      meta_q <= pins;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end
  logic rst_act;
  logic unhealthy;
  logic lrst_act;
  logic latch_closed;
  logic int_rst;
  logic latch_fall;
  logic latch_rise;
  logic opt_sample;
  assign rst_act      = !sync_q[HSF_PIN_RST];
  assign unhealthy    = sync_q[HSF_PIN_HLTHY] == HSF_HEALTHY_BAD;
  assign lrst_act     = !sync_q[HSF_PIN_LRST];
  assign latch_closed = sync_q[HSF_PIN_LATCH] == HSF_LATCH_CLOSED;   // [R03]
  assign int_rst      = rst_act || unhealthy;                        // [R04]
  assign latch_fall   = last_q[HSF_PIN_LATCH] && !sync_q[HSF_PIN_LATCH];
  assign latch_rise   = !last_q[HSF_PIN_LATCH] && sync_q[HSF_PIN_LATCH];
  assign opt_sample   = (last_q[HSF_PIN_HLTHY] && !sync_q[HSF_PIN_HLTHY])
                     || (!last_q[HSF_PIN_RST] && sync_q[HSF_PIN_RST])
                     || (!last_q[HSF_PIN_LRST] && sync_q[HSF_PIN_LRST]);

  // ----------------------------------------------------------------
  // Option pins, sampled on reset release edges
  // ----------------------------------------------------------------
  logic hold_meta_q;
  logic hold_sync_q;
  logic burst_meta_q;
  logic burst_sync_q;
  logic hold_off_q;
  logic burst_opt_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_meta_q  <= HSF_HOLD_RST;
      hold_sync_q  <= HSF_HOLD_RST;
      burst_meta_q <= HSF_BURST_RST;
      burst_sync_q <= HSF_BURST_RST;
    end else begin
      hold_meta_q  <= pci_hold_off_pin;
      hold_sync_q  <= hold_meta_q;
      burst_meta_q <= burst_option_pin;
      burst_sync_q <= burst_meta_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_off_q  <= HSF_HOLD_RST;
      burst_opt_q <= HSF_BURST_RST;
    end else if (opt_sample) begin
      hold_off_q  <= hold_sync_q;                                    // [R07]
      burst_opt_q <= burst_sync_q;                                   // [R07]
    end else if (local_wr.hold_off_clr) begin
      hold_off_q  <= HSF_HOLD_RST;                                   // [R11]
    end
  end

  // ----------------------------------------------------------------
  // Insertion and extraction sequencer
  // ----------------------------------------------------------------
  hsf_state_t state_q;
  logic       set_ins;
  logic       set_ext;
  assign set_ins = (state_q == HSF_S_LATCH && latch_closed)
                || (state_q == HSF_S_EJECT && latch_rise);           // [R16]
  assign set_ext = state_q == HSF_S_RUN && latch_fall;               // [R13]

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= HSF_S_RESET;
    end else if (int_rst) begin
      state_q <= HSF_S_RESET;                                        // [R05]
    end else begin
      unique case (state_q)
        HSF_S_RESET: state_q <= eeprom_load_en ? HSF_S_LOAD : HSF_S_HOLD;
        HSF_S_LOAD:  if (eeprom_done)  state_q <= HSF_S_HOLD;        // [R09]
        HSF_S_HOLD:  if (!hold_off_q)  state_q <= HSF_S_LATCH;       // [R10]
        HSF_S_LATCH: if (latch_closed) state_q <= HSF_S_RUN;
        HSF_S_RUN:   if (latch_fall)   state_q <= HSF_S_EJECT;
        HSF_S_EJECT: if (latch_rise)   state_q <= HSF_S_RUN;         // [R16]
      endcase
    end
  end

  // EEPROM load start, one cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      eeprom_start <= 1'b0;
    end else begin
      eeprom_start <= !int_rst && state_q == HSF_S_RESET
                   && eeprom_load_en;                                // [R08]
    end
  end

  // ----------------------------------------------------------------
  // Status flags; hardware set wins over host clear
  // ----------------------------------------------------------------
  logic ins_q;
  logic ext_q;
  logic mask_q;
  logic led_q;
  logic enum_q;
  logic accept_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ins_q <= HSF_FLAG_RST;
    end else if (int_rst) begin
      ins_q <= HSF_FLAG_RST;
    end else if (set_ins) begin
      ins_q <= 1'b1;                                                 // [R09] [R11]
    end else if (host_wr.ins_wr) begin
      ins_q <= 1'b0;                                                 // [R12]
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_q <= HSF_FLAG_RST;
    end else if (int_rst) begin
      ext_q <= HSF_FLAG_RST;
    end else if (set_ext) begin
      ext_q <= 1'b1;                                                 // [R13]
    end else if (host_wr.ext_wr) begin
      ext_q <= 1'b0;                                                 // [R14]
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_q <= HSF_MASK_RST;
      led_q  <= HSF_FLAG_RST;
    end else if (int_rst) begin
      mask_q <= HSF_MASK_RST;
      led_q  <= HSF_FLAG_RST;
    end else begin
      mask_q <= host_wr.mask_wr ? host_wr.mask_val : mask_q;
      led_q  <= host_wr.led_wr ? host_wr.led_val : led_q;            // [R15]
    end
  end

  // ENUM# request: masked events still set flags
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      enum_q <= 1'b0;
    end else if (int_rst) begin
      enum_q <= 1'b0;
    end else if ((set_ins || set_ext) && !mask_q) begin
      enum_q <= 1'b1;                                                // [R17]
    end else if (host_wr.ins_wr || host_wr.mask_wr || host_wr.ext_wr) begin
      enum_q <= 1'b0;                                                // [R12] [R14]
    end
  end
  // Config cycles accepted once insertion completes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      accept_q <= 1'b0;
    end else if (int_rst) begin
      accept_q <= 1'b0;
    end else if (set_ins) begin
      accept_q <= 1'b1;                                              // [R09] [R11]
    end
  end

  // ----------------------------------------------------------------
  // Soft local reset bit
  // ----------------------------------------------------------------
  logic soft_rst_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      soft_rst_q <= HSF_FLAG_RST;
    end else if (rst_act || lrst_act) begin
      soft_rst_q <= HSF_FLAG_RST;                                    // [R18]
    end else if (local_wr.soft_rst_wr) begin
      soft_rst_q <= local_wr.soft_rst_val;                           // [R18]
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers and status
  // ----------------------------------------------------------------
  logic lrst_drive_q;
  logic hiz_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      eject_led_oe <= 1'b1;
      enum_oe      <= 1'b0;
      lrst_drive_q <= 1'b0;
      hiz_q        <= 1'b1;
      cfg_accept   <= 1'b0;
      cfg_retry    <= 1'b0;
    end else begin
      eject_led_oe <= unhealthy || led_q;                            // [R01] [R02]
      enum_oe      <= enum_q && !int_rst;                            // [R09] [R13]
      lrst_drive_q <= !unhealthy && (rst_act || soft_rst_q);         // [R06] [R18]
      hiz_q        <= unhealthy;                                     // [R05]
      cfg_accept   <= accept_q && !int_rst;
      cfg_retry    <= !int_rst && !accept_q && hold_off_q;           // [R10]
    end
  end

  assign eject_led_out     = HSF_LED_LIT;                            // [R02]
  assign enum_out_n        = HSF_ENUM_ACT;
  assign local_reset_out_n = HSF_LRST_ACT;
  assign local_reset_oe    = lrst_drive_q;
  assign outputs_hiz       = hiz_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status <= '0;
    end else begin
      status <= {ins_q, ext_q, led_q, mask_q, hold_off_q, soft_rst_q,
                 burst_opt_q};
    end
  end

endmodule

`default_nettype wire

// ### verif/hsf_ctrl_checker.sv
// Port-level assertions for the hot swap control block
`timescale 1ns/100ps
`default_nettype none
module hsf_ctrl_checker
  import hsf_pkg::*;
(
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 reset_n,
  // Pins and strobes
  input wire logic                 pci_rst_n,
  input wire logic                 board_healthy_n,
  input wire hsf_pkg::hsf_host_wr_t host_wr,
  // Outputs watched
  input wire logic                 eject_led_out,
  input wire logic                 eject_led_oe,
  input wire logic                 enum_oe,
  input wire logic                 local_reset_oe,
  input wire logic                 eeprom_start,
  input wire hsf_pkg::hsf_status_t status,
  input wire logic                 cfg_accept,
  input wire logic                 cfg_retry,
  input wire logic                 outputs_hiz
);
  // --------------------------------------------------------------
  // Pins and resets
  // --------------------------------------------------------------
  a_led_unhealthy: assert property (
    @(posedge clk) disable iff (!reset_n)
    board_healthy_n [*5] |-> eject_led_oe) else $error("LED dark");
  a_led_released: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!board_healthy_n [*5] ##0 !status.led_on_bit)
    |-> !eject_led_oe && eject_led_out == HSF_LED_LIT)
    else $error("LED pin not released");
  a_all_hiz: assert property (
    @(posedge clk) disable iff (!reset_n)
    board_healthy_n [*5] |-> outputs_hiz && !enum_oe && !local_reset_oe
    && !cfg_accept) else $error("output driven while unhealthy");
  a_lrst_drive: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!board_healthy_n && !pci_rst_n) [*5] |-> local_reset_oe)
    else $error("local reset not driven");
  // --------------------------------------------------------------
  // Sequencing and flags
  // --------------------------------------------------------------
  a_start_pulse: assert property (
    @(posedge clk) disable iff (!reset_n)
    eeprom_start |=> !eeprom_start) else $error("start not a pulse");
  a_ins_enum: assert property (
    @(posedge clk) disable iff (!reset_n)
    $rose(status.insertion_flag)
    |-> cfg_accept && (enum_oe == !status.enum_mask_bit))
    else $error("insertion without accept or ENUM");
  a_ext_enum: assert property (
    @(posedge clk) disable iff (!reset_n)
    $rose(status.extraction_flag) |-> enum_oe == !status.enum_mask_bit)
    else $error("extraction ENUM wrong");
  a_ins_clear: assert property (
    @(posedge clk) disable iff (!reset_n)
    host_wr.ins_wr |-> ##2 !status.insertion_flag && !enum_oe)
    else $error("insertion write did not clear");
  a_ext_clear: assert property (
    @(posedge clk) disable iff (!reset_n)
    host_wr.ext_wr |-> ##2 !status.extraction_flag && !enum_oe)
    else $error("extraction write did not clear");
  a_mask_release: assert property (
    @(posedge clk) disable iff (!reset_n)
    host_wr.mask_wr |-> ##2 !enum_oe) else $error("mask write kept ENUM");
  a_retry_hold: assert property (
    @(posedge clk) disable iff (!reset_n)
    cfg_retry |-> !enum_oe && !cfg_accept) else $error("retry with ENUM");
  a_soft_reset: assert property (
    @(posedge clk) disable iff (!reset_n)
    $rose(status.soft_local_reset_bit) && !outputs_hiz
    |-> ##[0:1] local_reset_oe)
    else $error("soft reset not driven");
endmodule
bind hsf_ctrl hsf_ctrl_checker u_chk (.clk(clk), .reset_n(reset_n),
  .pci_rst_n(pci_rst_n), .board_healthy_n(board_healthy_n),
  .host_wr(host_wr), .eject_led_out(eject_led_out),
  .eject_led_oe(eject_led_oe), .enum_oe(enum_oe),
  .local_reset_oe(local_reset_oe), .eeprom_start(eeprom_start),
  .status(status), .cfg_accept(cfg_accept), .cfg_retry(cfg_retry),
  .outputs_hiz(outputs_hiz));
`default_nettype wire

// ### verif/hsf_eeprom_model.sv
// Serial EEPROM loader stand-in, prompt or slow
`timescale 1ns/100ps
`default_nettype none
module hsf_eeprom_model (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic eeprom_start,
  input  wire logic slow,
  output logic      eeprom_done
);
  int cnt;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 0;
      eeprom_done <= 1'b0;
    end else begin
      cnt <= eeprom_start ? (slow ? 20 : 1) : (cnt != 0 ? cnt - 1 : 0);
      eeprom_done <= (cnt == 1);
    end
  end
endmodule
`default_nettype wire

// ### verif/hsf_ctrl_bench.sv
// Self-checking bench for the hot swap control block
`timescale 1ns/100ps
`default_nettype none
module hsf_ctrl_bench;
  import hsf_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, pci_rst_n = 1'b0, board_healthy_n = 1'b1;
  logic local_reset_in_n = 1'b1, latch_switch_in = 1'b1, slow = 1'b0;
  logic pci_hold_off_pin = 1'b0, burst_option_pin = 1'b0, bval;
  logic eeprom_load_en = 1'b1, eeprom_start, eeprom_done;
  logic eject_led_out, eject_led_oe, enum_out_n, enum_oe, outputs_hiz;
  logic local_reset_out_n, local_reset_oe, cfg_accept, cfg_retry;
  hsf_host_wr_t  host_wr = '0;
  hsf_local_wr_t local_wr = '0;
  hsf_status_t   status;
  int mismatches = 0, total_checks = 0, starts = 0, seed = 32'h87C3;
  int e_ins = 0, e_ext = 0, e_enum = 0, e_led = 1, e_mask = 0;
  int e_loo = 0, e_hold = 0, e_soft = 0;

  always #20 clk = ~clk;
  always @(posedge clk) if (eeprom_start === 1'b1) starts++;

  hsf_ctrl dut (.clk(clk), .reset_n(reset_n), .pci_rst_n(pci_rst_n),
    .board_healthy_n(board_healthy_n), .local_reset_in_n(local_reset_in_n),
    .latch_switch_in(latch_switch_in), .pci_hold_off_pin(pci_hold_off_pin),
    .burst_option_pin(burst_option_pin), .eject_led_out(eject_led_out),
    .eject_led_oe(eject_led_oe), .enum_out_n(enum_out_n),
    .enum_oe(enum_oe), .local_reset_out_n(local_reset_out_n),
    .local_reset_oe(local_reset_oe), .eeprom_load_en(eeprom_load_en),
    .eeprom_start(eeprom_start), .eeprom_done(eeprom_done),
    .host_wr(host_wr), .local_wr(local_wr), .status(status),
    .cfg_accept(cfg_accept), .cfg_retry(cfg_retry),
    .outputs_hiz(outputs_hiz));
  hsf_eeprom_model u_eep (.clk(clk), .reset_n(reset_n),
    .eeprom_start(eeprom_start), .slow(slow), .eeprom_done(eeprom_done));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic model();
    chk({status.insertion_flag, status.extraction_flag, enum_oe,
      eject_led_oe, status.enum_mask_bit}, {e_ins[0], e_ext[0], e_enum[0],
      e_led[0], e_mask[0]});
    chk({status.led_on_bit, status.pci_hold_off, status.soft_local_reset_bit,
      enum_out_n, local_reset_out_n}, {e_loo[0], e_hold[0], e_soft[0],
      HSF_ENUM_ACT, HSF_LRST_ACT});
  endtask
  task automatic hw(input hsf_host_wr_t v);
    host_wr = v;
    step(1);
    host_wr = '0;
    step(3);
  endtask
  task automatic lw(input hsf_local_wr_t v);
    local_wr = v;
    step(1);
    local_wr = '0;
    step(3);
  endtask
  task automatic wait_acc();
    int i;
    for (i = 0; i < 200 && cfg_accept !== 1'b1; i++) step(1);
    if (cfg_accept !== 1'b1) begin
      mismatches++;
      stop_test();
    end else begin
      step(2);
    end
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    burst_option_pin = 1'($random(seed));
    slow = 1'($random(seed));
    step(10);
    reset_n = 1'b1;
    step(6);
    chk({1'h0, enum_oe, eject_led_oe, outputs_hiz, local_reset_oe}, 5'h06);
    board_healthy_n = 1'b0;
    step(6);
    chk({2'h0, eject_led_oe, outputs_hiz, local_reset_oe}, 5'h01);
    bval = burst_option_pin;
    pci_rst_n = 1'b1;
    wait_acc();
    chk({4'h0, status.burst_option}, {4'h0, bval});
    burst_option_pin = ~bval;
    chk(5'(starts), 5'h01);
    e_led = 0; e_ins = 1; e_enum = 1; model();
    $display("test 1 done");
    hw(6'h20); e_ins = 0; e_enum = 0; model();
    latch_switch_in = 1'b0;
    step(6); e_ext = 1; e_enum = 1; model();
    hw(6'h10); e_ext = 0; e_enum = 0; model();
    hw(6'h03); e_led = 1; e_loo = 1; model();
    latch_switch_in = 1'b1;
    step(6); e_ins = 1; e_enum = 1; model();
    chk(5'(starts), 5'h01);
    chk({4'h0, status.burst_option}, {4'h0, bval});
    hw(6'h02); hw(6'h20); e_led = 0; e_loo = 0;
    e_ins = 0; e_enum = 0; model();
    $display("test 2 done");
    hw(6'h0C); e_mask = 1; latch_switch_in = 1'b0;
    step(6); e_ext = 1; model();
    hw(6'h10); e_ext = 0; latch_switch_in = 1'b1;
    step(6); e_ins = 1; model();
    hw(6'h08); e_mask = 0; model();
    lw(3'h3); chk({4'h0, local_reset_oe}, 5'h01);
    e_soft = 1; model();
    local_reset_in_n = 1'b0;
    step(6); chk({4'h0, local_reset_oe}, 5'h00);
    e_soft = 0; model();
    local_reset_in_n = 1'b1;
    step(4);
    $display("test 3 done");
    pci_hold_off_pin = 1'b1; eeprom_load_en = 1'b0; board_healthy_n = 1'b1;
    step(6); e_ins = 0; e_led = 1; model();
    board_healthy_n = 1'b0;
    step(8); e_led = 0; e_hold = 1; model();
    chk({3'h0, cfg_retry, cfg_accept}, 5'h02);
    chk({4'h0, status.burst_option}, {4'h0, ~bval});
    lw(3'h4);
    wait_acc(); e_ins = 1; e_enum = 1; e_hold = 0; model();
    $display("test 4 done");
    stop_test();
  end
endmodule
`default_nettype wire
